// ==== hw/fpg_pkg.sv ====
// Shared constants and types for the flash port access guard.
// Assumes a processor clock domain and a separate flash link clock domain.
//
// Overview of operation
// - While select is low, data moves on serial out and serial in, paced by the serial clock.
// - A basic transaction lasts exactly as long as select is low and is finished once select is high.
// - A new basic transaction starts only after the previous one has fully completed.
// - Complex functions run as an ordered series of separate select-framed basic transactions.
// - Instruction and constant fetches are started by hardware on request, with no software step.
// - Fetch requests from main-loop and handler code are arbitrated so they never collide.
// - A basic transaction is never broken into by another requester, fetch or software.
// - An interrupt raised while masked is held pending and never dropped.
// - On unmask a pending interrupt is raised only once no software transaction holds the port.
package fpg_pkg;

	// ----------------------------------------------------------------
	// Serial framing
	// ----------------------------------------------------------------
	localparam logic [7:0] FETCH_CMD   = 8'h03; // Plain read command for fetches
	localparam logic [7:0] DUMMY_BYTE  = 8'h00; // Clocked out while reading data
	localparam logic [4:0] BIT_PHASES  = 5'h10; // Two link cycles per bit, eight bits
	localparam logic [4:0] PHASE_FIRST = 5'h00;
	localparam int         SYNC_DEPTH  = 3;

	// ----------------------------------------------------------------
	// Link operations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FPG_OP_OPEN  = 2'h0, // Drive select low
		FPG_OP_XFER  = 2'h1, // Exchange one byte
		FPG_OP_CLOSE = 2'h2  // Drive select high
	} fpg_op_e;

	typedef struct packed {
		fpg_op_e    kind;
		logic [7:0] data;
	} fpg_op_s;

	localparam fpg_op_s OP_RESET = '{kind: FPG_OP_CLOSE, data: 8'h00};

	// ----------------------------------------------------------------
	// Arbiter states, Gray coded along the fetch path only
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FPG_ST_IDLE     = 3'h0,
		FPG_ST_OPEN     = 3'h1,
		FPG_ST_XFER     = 3'h3,
		FPG_ST_CLOSE    = 3'h2,
		FPG_ST_SW_OPEN  = 3'h6,
		FPG_ST_SW_HOLD  = 3'h7,
		FPG_ST_SW_XFER  = 3'h5,
		FPG_ST_SW_CLOSE = 3'h4
	} fpg_state_e;

endpackage : fpg_pkg

// ==== hw/fpg_serial.sv ====
// Serial engine of the flash port, in the link clock domain.
// Assumes ops arrive by toggle handshake with the op word held stable until acknowledged.
module fpg_serial (
	input  wire logic            link_clk_i,
	input  wire logic            sys_rst_i,
	input  wire logic            req_tgl_i,
	input  wire fpg_pkg::fpg_op_s op_i,
	output logic                 ack_tgl_o,
	output logic [7:0]           rx_o,
	output logic                 flash_select_n_o,
	output logic                 flash_sclk_o,
	output logic                 flash_serial_out_o,
	input  wire logic            flash_serial_in_i
);

	// ----------------------------------------------------------------
	// Reset release synchroniser
	// ----------------------------------------------------------------
	logic [1:0] rst_q;
	logic       link_rst;

	// Assert at once, release on link clock so no flop sees a runt release
	always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rst_q <= 2'h3;
		end else begin
			rst_q <= {rst_q[0], 1'b0};
		end
	end
	assign link_rst = rst_q[1];

	// ----------------------------------------------------------------
	// Request toggle synchroniser and byte shifter
	// ----------------------------------------------------------------
	logic [fpg_pkg::SYNC_DEPTH-1:0] req_s_q;
	logic       seen_q, seen_d;
	logic       busy_q, busy_d;
	logic [4:0] phase_q, phase_d;
	logic [7:0] sr_q, sr_d;
	logic       ack_d, sel_n_d, sclk_d, so_d;
	logic [7:0] rx_d;
	logic       req_evt;

	// A change counts only once the last two stages agree
	assign req_evt = (req_s_q[1] == req_s_q[2]) && (req_s_q[2] != seen_q);

	always_comb begin
		seen_d  = seen_q;
		busy_d  = busy_q;
		phase_d = phase_q;
		sr_d    = sr_q;
		ack_d   = ack_tgl_o;
		rx_d    = rx_o;
		sel_n_d = flash_select_n_o;
		sclk_d  = flash_sclk_o;
		so_d    = flash_serial_out_o;
		if (busy_q) begin
			// Data changes while clock is low, sampled while it is high
			phase_d = phase_q + 5'h01;
			if (phase_q[0]) begin
				sclk_d = 1'b1;
			end else begin
				sclk_d = 1'b0;
				sr_d   = {sr_q[6:0], flash_serial_in_i};
				so_d   = sr_q[6];
			end
			if (phase_q == fpg_pkg::BIT_PHASES) begin
				busy_d = 1'b0;
				sclk_d = 1'b0;
				rx_d   = {sr_q[6:0], flash_serial_in_i};
				ack_d  = ~ack_tgl_o;
			end
		end else if (req_evt) begin
			seen_d = req_s_q[2];
			case (op_i.kind)
				fpg_pkg::FPG_OP_OPEN: begin
					sel_n_d = 1'b0;
					ack_d   = ~ack_tgl_o;
				end
				fpg_pkg::FPG_OP_XFER: begin
					busy_d  = 1'b1;
					phase_d = fpg_pkg::PHASE_FIRST + 5'h01;
					sr_d    = op_i.data;
					so_d    = op_i.data[7];
					sclk_d  = 1'b0;
				end
				default: begin
					sel_n_d = 1'b1;
					so_d    = 1'b0;
					ack_d   = ~ack_tgl_o;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_i or posedge link_rst) begin
		if (link_rst) begin
			req_s_q            <= '0;
			seen_q             <= 1'b0;
			busy_q             <= 1'b0;
			phase_q            <= fpg_pkg::PHASE_FIRST;
			sr_q               <= 8'h00;
			ack_tgl_o          <= 1'b0;
			rx_o               <= 8'h00;
			flash_select_n_o   <= 1'b1;
			flash_sclk_o       <= 1'b0;
			flash_serial_out_o <= 1'b0;
		end else begin
			req_s_q            <= {req_s_q[1:0], req_tgl_i};
			seen_q             <= seen_d;
			busy_q             <= busy_d;
			phase_q            <= phase_d;
			sr_q               <= sr_d;
			ack_tgl_o          <= ack_d;
			rx_o               <= rx_d;
			flash_select_n_o   <= sel_n_d;
			flash_sclk_o       <= sclk_d;
			flash_serial_out_o <= so_d;
		end
	end

endmodule : fpg_serial

// ==== hw/fpg_guard.sv ====
// Flash port access guard: arbitrates hardware fetches and software
// transactions on one serial flash port and holds interrupts meanwhile.
// Assumes requesters on ref_clk_i and a free-running link clock for the port.
module fpg_guard #(
	parameter int ADDR_W = 24
) (
	input  wire logic              ref_clk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              link_clk_i,
	// Hardware fetch ports: index 0 main loop, index 1 interrupt handler
	input  wire logic [1:0]        fetch_req_i,
	input  wire logic [ADDR_W-1:0] fetch_main_addr_i,
	input  wire logic [ADDR_W-1:0] fetch_irq_addr_i,
	output logic [1:0]             fetch_done_o,
	output logic [7:0]             fetch_data_o,
	// Software transaction port
	input  wire logic              sw_own_i,
	input  wire logic              sw_byte_valid_i,
	input  wire logic [7:0]        sw_byte_i,
	output logic                   sw_ready_o,
	output logic                   sw_done_o,
	output logic [7:0]             sw_rx_o,
	output logic                   sw_active_o,
	// Interrupt hold
	input  wire logic              irq_req_i,
	input  wire logic              irq_mask_i,
	input  wire logic              irq_ack_i,
	output logic                   irq_o,
	// Flash pins
	output logic                   flash_select_n_o,
	output logic                   flash_sclk_o,
	output logic                   flash_serial_out_o,
	input  wire logic              flash_serial_in_i
);

	localparam int          NB       = ADDR_W / 8;
	localparam logic [2:0]  LAST_IDX = 3'(NB + 1); // Address bytes then one data byte

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W % 8 != 0 || ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
		$error("ADDR_W must be 8, 16, 24 or 32");
	end

	// ----------------------------------------------------------------
	// Link engine and acknowledge crossing
	// ----------------------------------------------------------------
	logic             req_tgl_q, req_tgl_d;
	fpg_pkg::fpg_op_s op_q, op_d;
	logic             ack_tgl;
	logic [7:0]       link_rx;
	logic [fpg_pkg::SYNC_DEPTH-1:0] ack_s_q;
	logic             ack_seen_q;
	logic             ack_evt;

	fpg_serial u_serial (
		.link_clk_i         (link_clk_i),
		.sys_rst_i          (sys_rst_i),
		.req_tgl_i          (req_tgl_q),
		.op_i               (op_q),
		.ack_tgl_o          (ack_tgl),
		.rx_o               (link_rx),
		.flash_select_n_o   (flash_select_n_o),
		.flash_sclk_o       (flash_sclk_o),
		.flash_serial_out_o (flash_serial_out_o),
		.flash_serial_in_i  (flash_serial_in_i)
	);

	// Received byte is stable once the acknowledge toggle has crossed
	assign ack_evt = (ack_s_q[1] == ack_s_q[2]) && (ack_s_q[2] != ack_seen_q);

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack_s_q    <= '0;
			ack_seen_q <= 1'b0;
		end else begin
			ack_s_q    <= {ack_s_q[1:0], ack_tgl};
			ack_seen_q <= ack_evt ? ack_s_q[2] : ack_seen_q;
		end
	end

	// ----------------------------------------------------------------
	// Address byte select
	// ----------------------------------------------------------------
	function automatic logic [7:0] fetch_byte(input logic [ADDR_W-1:0] addr, input logic [2:0] idx);
		logic [7:0] b;
		b = fpg_pkg::DUMMY_BYTE;
		for (int i = 1; i <= NB; i++) begin
			if (idx == 3'(i)) begin
				b = addr[ADDR_W-8*(i-1)-1 -: 8];
			end
		end
		return b;
	endfunction : fetch_byte

	// ----------------------------------------------------------------
	// Port arbiter and sequencer
	// ----------------------------------------------------------------
	fpg_pkg::fpg_state_e st_q, st_d;
	logic              owner_q, owner_d;
	logic [2:0]        idx_q, idx_d;
	logic [1:0]        fdone_d;
	logic [7:0]        fdata_d;
	logic              swdone_d;
	logic [7:0]        swrx_d;
	logic [ADDR_W-1:0] cur_addr;

	assign cur_addr = owner_q ? fetch_irq_addr_i : fetch_main_addr_i;

	// Every op waits for the previous acknowledge, so the link never overlaps
	always_comb begin
		st_d      = st_q;
		owner_d   = owner_q;
		idx_d     = idx_q;
		op_d      = op_q;
		req_tgl_d = req_tgl_q;
		fdone_d   = 2'h0;
		fdata_d   = fetch_data_o;
		swdone_d  = 1'b0;
		swrx_d    = sw_rx_o;
		case (st_q)
			fpg_pkg::FPG_ST_IDLE: begin
				if (fetch_req_i != 2'h0) begin
					// Handler fetch wins a tie; the loser stays requested
					owner_d   = fetch_req_i[1];
					op_d      = '{kind: fpg_pkg::FPG_OP_OPEN, data: 8'h00};
					req_tgl_d = ~req_tgl_q;
					st_d      = fpg_pkg::FPG_ST_OPEN;
				end else if (sw_own_i) begin
					// Software only gets the port with no fetch in flight
					op_d      = '{kind: fpg_pkg::FPG_OP_OPEN, data: 8'h00};
					req_tgl_d = ~req_tgl_q;
					st_d      = fpg_pkg::FPG_ST_SW_OPEN;
				end
			end
			fpg_pkg::FPG_ST_OPEN: begin
				if (ack_evt) begin
					idx_d     = 3'h0;
					op_d      = '{kind: fpg_pkg::FPG_OP_XFER, data: fpg_pkg::FETCH_CMD};
					req_tgl_d = ~req_tgl_q;
					st_d      = fpg_pkg::FPG_ST_XFER;
				end
			end
			fpg_pkg::FPG_ST_XFER: begin
				if (ack_evt) begin
					if (idx_q == LAST_IDX) begin
						fdata_d   = link_rx;
						op_d      = '{kind: fpg_pkg::FPG_OP_CLOSE, data: 8'h00};
						req_tgl_d = ~req_tgl_q;
						st_d      = fpg_pkg::FPG_ST_CLOSE;
					end else begin
						idx_d     = idx_q + 3'h1;
						op_d      = '{kind: fpg_pkg::FPG_OP_XFER,
						              data: fetch_byte(cur_addr, idx_q + 3'h1)};
						req_tgl_d = ~req_tgl_q;
					end
				end
			end
			fpg_pkg::FPG_ST_CLOSE: begin
				if (ack_evt) begin
					fdone_d[owner_q] = 1'b1;
					st_d             = fpg_pkg::FPG_ST_IDLE;
				end
			end
			fpg_pkg::FPG_ST_SW_OPEN: begin
				if (ack_evt) begin
					st_d = fpg_pkg::FPG_ST_SW_HOLD;
				end
			end
			fpg_pkg::FPG_ST_SW_HOLD: begin
				// Fetches stay queued until software lets select go high
				if (sw_byte_valid_i) begin
					op_d      = '{kind: fpg_pkg::FPG_OP_XFER, data: sw_byte_i};
					req_tgl_d = ~req_tgl_q;
					st_d      = fpg_pkg::FPG_ST_SW_XFER;
				end else if (!sw_own_i) begin
					op_d      = '{kind: fpg_pkg::FPG_OP_CLOSE, data: 8'h00};
					req_tgl_d = ~req_tgl_q;
					st_d      = fpg_pkg::FPG_ST_SW_CLOSE;
				end
			end
			fpg_pkg::FPG_ST_SW_XFER: begin
				if (ack_evt) begin
					swdone_d = 1'b1;
					swrx_d   = link_rx;
					st_d     = fpg_pkg::FPG_ST_SW_HOLD;
				end
			end
			fpg_pkg::FPG_ST_SW_CLOSE: begin
				if (ack_evt) begin
					st_d = fpg_pkg::FPG_ST_IDLE;
				end
			end
			default: begin
				st_d = fpg_pkg::FPG_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q         <= fpg_pkg::FPG_ST_IDLE;
			owner_q      <= 1'b0;
			idx_q        <= 3'h0;
			op_q         <= fpg_pkg::OP_RESET;
			req_tgl_q    <= 1'b0;
			fetch_done_o <= 2'h0;
			fetch_data_o <= 8'h00;
			sw_done_o    <= 1'b0;
			sw_rx_o      <= 8'h00;
		end else begin
			st_q         <= st_d;
			owner_q      <= owner_d;
			idx_q        <= idx_d;
			op_q         <= op_d;
			req_tgl_q    <= req_tgl_d;
			fetch_done_o <= fdone_d;
			fetch_data_o <= fdata_d;
			sw_done_o    <= swdone_d;
			sw_rx_o      <= swrx_d;
		end
	end

	// ----------------------------------------------------------------
	// Software status and interrupt hold
	// ----------------------------------------------------------------
	logic sw_act_d;
	logic ready_d;
	logic pend_q, pend_d;
	logic irq_d;

	// Status follows the next state so ready lines up with the hold state
	always_comb begin
		sw_act_d = st_d[2];
		ready_d  = (st_d == fpg_pkg::FPG_ST_SW_HOLD);
		// A new request in the acknowledge cycle is kept, set beats clear
		pend_d   = (pend_q & ~irq_ack_i) | irq_req_i;
		// Held back while masked or while software owns the port
		irq_d    = pend_d & ~irq_mask_i & ~sw_act_d;
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sw_active_o <= 1'b0;
			sw_ready_o  <= 1'b0;
			pend_q      <= 1'b0;
			irq_o       <= 1'b0;
		end else begin
			sw_active_o <= sw_act_d;
			sw_ready_o  <= ready_d;
			pend_q      <= pend_d;
			irq_o       <= irq_d;
		end
	end

endmodule : fpg_guard

// ==== dv/fpg_flash_model.sv ====
// Behavioural serial flash for the port guard bench, mode 0 framing.
// Assumes select low opens a frame and sclk idles low between bytes.
// Each byte answered is the byte taken just before it xor 0x5a (0x5a first in a frame).
module fpg_flash_model (
	input  wire logic flash_select_n_i,
	input  wire logic flash_sclk_i,
	input  wire logic flash_serial_out_i,
	output logic      flash_serial_in_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] rx_q;
	logic [7:0] tx_q;
	int         bits;

	initial flash_serial_in_o = 1'b0;

	// Frame opens: first answer bit must be out before the first rising sclk
	always @(negedge flash_select_n_i) begin
		bits = 0;
		rx_q = 8'h00;
		tx_q = 8'h5a;
		flash_serial_in_o = tx_q[7];
	end

	// Take one bit on each rising sclk inside the frame
	always @(posedge flash_sclk_i) begin
		if (!flash_select_n_i) begin
			rx_q = {rx_q[6:0], flash_serial_out_i};
			bits++;
		end
	end

	// Move to the next answer bit on falling sclk, new byte at each boundary
	always @(negedge flash_sclk_i) begin
		if (!flash_select_n_i) begin
			if (bits % 8 == 0) tx_q = rx_q ^ 8'h5a;
			else tx_q = {tx_q[6:0], 1'b0};
			flash_serial_in_o = tx_q[7];
		end
	end

	// Released line carries no data; inverting it stops a stale bit looking valid
	always @(posedge flash_select_n_i) flash_serial_in_o = ~flash_serial_in_o;
endmodule : fpg_flash_model

// ==== dv/fpg_guard_chk.sv ====
// Port checker for the flash port access guard.
// Assumes it is bound to the guard top and sees only its ports.
module fpg_guard_chk (
	input wire logic       ref_clk_i,
	input wire logic       sys_rst_i,
	input wire logic       link_clk_i,
	input wire logic [1:0] fetch_done_o,
	input wire logic       sw_own_i,
	input wire logic       sw_byte_valid_i,
	input wire logic       sw_ready_o,
	input wire logic       sw_done_o,
	input wire logic       sw_active_o,
	input wire logic       irq_req_i,
	input wire logic       irq_mask_i,
	input wire logic       irq_ack_i,
	input wire logic       irq_o,
	input wire logic       flash_select_n_o,
	input wire logic       flash_sclk_o,
	input wire logic       flash_serial_out_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Sclk rising edges in the current frame
	// ----------------------------------------------------------------
	logic [7:0] edges_q;
	logic [7:0] edges_d;
	logic       sclk_q;

	// Cleared while select is high so a frame is counted on its own
	always_comb begin
		edges_d = edges_q;
		if (flash_select_n_o) edges_d = 8'h00;
		else if (flash_sclk_o && !sclk_q) edges_d = edges_q + 8'h01;
	end

	// Registers only
	always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			edges_q <= 8'h00;
			sclk_q  <= 1'b0;
		end else begin
			edges_q <= edges_d;
			sclk_q  <= flash_sclk_o;
		end
	end

	// ----------------------------------------------------------------
	// Sequences and properties
	// ----------------------------------------------------------------
	sequence s_irq_raised;
		irq_req_i && !irq_mask_i && !sw_active_o ##1 !irq_mask_i && !sw_active_o && !irq_ack_i;
	endsequence
	// Software asking for the port may lawfully hold the line back, so only a quiet port counts
	sequence s_irq_held;
		(irq_o && !irq_ack_i && !irq_mask_i && !sw_active_o && !sw_own_i)[*2];
	endsequence

	AST_SCLK_IN_FRAME: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		flash_sclk_o |-> !flash_select_n_o) else $error("sclk high outside a frame");
	AST_OUT_STEADY: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		flash_sclk_o |-> $stable(flash_serial_out_o)) else $error("serial out moved while sclk high");
	AST_CLOSE_SCLK_LOW: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		$rose(flash_select_n_o) |-> !flash_sclk_o) else $error("frame closed with sclk high");
	AST_WHOLE_BYTES: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		$rose(flash_select_n_o) |-> edges_q[2:0] == 3'h0) else $error("frame closed mid byte");
	AST_FETCH_EXCL: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		fetch_done_o != 2'h0 |-> !sw_active_o) else $error("fetch finished inside software frame");
	AST_FETCH_SOLO: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		$onehot0(fetch_done_o)) else $error("two fetches finished together");
	AST_READY_DROP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		sw_ready_o && sw_byte_valid_i |=> !sw_ready_o && !sw_done_o) else $error("ready stayed after byte taken");
	AST_READY_OPEN: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		sw_ready_o |-> sw_active_o) else $error("ready outside software frame");
	AST_IRQ_GATED: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		$rose(irq_o) |-> !$past(irq_mask_i)) else $error("interrupt raised while masked");
	AST_IRQ_RAISE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		s_irq_raised |-> ##[0:1] irq_o) else $error("unmasked interrupt not raised");
	AST_IRQ_KEEP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		s_irq_held |=> irq_o) else $error("pending interrupt dropped");
endmodule : fpg_guard_chk

// ==== dv/test_fpg_guard.sv ====
// Self-checking bench for the flash port access guard.
// Assumes the behavioural flash model and a free-running link clock.
module test_fpg_guard;
	timeunit 1ns;
	timeprecision 1ns;

	logic        ref_clk_i = 1'b0;
	logic        link_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [1:0]  fetch_req_i = 2'h0;
	logic [23:0] fetch_main_addr_i = 24'h000000;
	logic [23:0] fetch_irq_addr_i = 24'h000000;
	logic        sw_own_i = 1'b0;
	logic        sw_byte_valid_i = 1'b0;
	logic [7:0]  sw_byte_i = 8'h00;
	logic        irq_req_i = 1'b0;
	logic        irq_mask_i = 1'b0;
	logic        irq_ack_i = 1'b0;
	logic [1:0]  fetch_done_o;
	logic [7:0]  fetch_data_o;
	logic [7:0]  sw_rx_o;
	logic        sw_ready_o, sw_done_o, sw_active_o, irq_o;
	logic        flash_select_n_o, flash_sclk_o, flash_serial_out_o, flash_serial_in_i;
	int          err_total = 0;
	int          total_checks = 0;

	// Protection bytes for the update frames; values are arbitrary bench picks
	localparam logic [7:0] UNLOCK_CMD = 8'h2d;
	localparam logic [7:0] LOCK_CMD   = 8'h2e;
	localparam logic [7:0] PROT_NONE  = 8'h00;
	localparam logic [7:0] PROT_ALL   = 8'h1c;

	// Link clock offset so its edges never line up with the processor clock
	always #50 ref_clk_i = ~ref_clk_i;
	initial begin
		#7;
		forever #24 link_clk_i = ~link_clk_i;
	end

	fpg_guard u_fpg_guard (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i),
		.fetch_req_i(fetch_req_i), .fetch_main_addr_i(fetch_main_addr_i), .fetch_irq_addr_i(fetch_irq_addr_i),
		.fetch_done_o(fetch_done_o), .fetch_data_o(fetch_data_o), .sw_own_i(sw_own_i),
		.sw_byte_valid_i(sw_byte_valid_i), .sw_byte_i(sw_byte_i), .sw_ready_o(sw_ready_o), .sw_done_o(sw_done_o),
		.sw_rx_o(sw_rx_o), .sw_active_o(sw_active_o), .irq_req_i(irq_req_i), .irq_mask_i(irq_mask_i),
		.irq_ack_i(irq_ack_i), .irq_o(irq_o), .flash_select_n_o(flash_select_n_o), .flash_sclk_o(flash_sclk_o),
		.flash_serial_out_o(flash_serial_out_o), .flash_serial_in_i(flash_serial_in_i));

	fpg_flash_model u_fpg_flash_model (.flash_select_n_i(flash_select_n_o), .flash_sclk_i(flash_sclk_o),
		.flash_serial_out_i(flash_serial_out_o), .flash_serial_in_o(flash_serial_in_i));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait for one done bit, then the request is dropped before the next edge
	task automatic fetch_wait(input int idx, input logic [7:0] exp);
		int n;
		n = 0;
		while (fetch_done_o[idx] !== 1'b1 && n < 300) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk({7'h00, fetch_done_o[idx]}, 8'h01);
		chk(fetch_data_o, exp);
		fetch_req_i[idx] = 1'b0;
	endtask : fetch_wait

	// Byte is held until taken at a ready edge, then the answer is awaited
	task automatic sw_byte(input logic [7:0] b, input logic [7:0] exp);
		int n;
		n = 0;
		while (sw_ready_o !== 1'b1 && n < 300) begin
			@(negedge ref_clk_i);
			n++;
		end
		sw_byte_i = b;
		sw_byte_valid_i = 1'b1;
		@(negedge ref_clk_i);
		sw_byte_valid_i = 1'b0;
		n = 0;
		while (sw_done_o !== 1'b1 && n < 300) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk(sw_rx_o, exp);
	endtask : sw_byte

	// Two byte software frame, then select is released and must read high before anything else
	task automatic sw_frame(input logic [7:0] b0, input logic [7:0] b1);
		int n;
		n = 0;
		sw_own_i = 1'b1;
		sw_byte(b0, 8'h5a);
		sw_byte(b1, b0 ^ 8'h5a);
		sw_own_i = 1'b0;
		while (sw_active_o !== 1'b0 && n < 300) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk({7'h00, sw_active_o}, 8'h00);
		chk({7'h00, flash_select_n_o}, 8'h01);
	endtask : sw_frame

	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_fetch;
		fetch_main_addr_i = 24'h1234a7;
		fetch_irq_addr_i = 24'hfedc01;
		fetch_req_i = 2'h1;
		fetch_wait(0, 8'ha7 ^ 8'h5a);
		@(negedge ref_clk_i);
		fetch_req_i = 2'h2;
		fetch_wait(1, 8'h01 ^ 8'h5a);
		@(negedge ref_clk_i);
		fetch_req_i = 2'h3;
		fetch_wait(1, 8'h01 ^ 8'h5a);
		fetch_wait(0, 8'ha7 ^ 8'h5a);
		$display("test fetch finished");
	endtask : t_fetch

	// Fetch and masked interrupt arrive mid frame; the fetch must wait for the frame to close, the interrupt for unmask
	task automatic t_sw_guard;
		sw_own_i = 1'b1;
		irq_mask_i = 1'b1;
		sw_byte(8'h9f, 8'h5a);
		fetch_main_addr_i = 24'h0001c3;
		fetch_req_i = 2'h1;
		irq_req_i = 1'b1;
		@(negedge ref_clk_i);
		irq_req_i = 1'b0;
		sw_byte(8'h3c, 8'h9f ^ 8'h5a);
		chk({7'h00, flash_select_n_o}, 8'h00);
		chk({6'h00, fetch_done_o}, 8'h00);
		chk({7'h00, irq_o}, 8'h00);
		sw_own_i = 1'b0;
		fetch_wait(0, 8'hc3 ^ 8'h5a);
		chk({7'h00, irq_o}, 8'h00);
		irq_mask_i = 1'b0;
		repeat (3) @(negedge ref_clk_i);
		chk({7'h00, irq_o}, 8'h01);
		irq_ack_i = 1'b1;
		@(negedge ref_clk_i);
		irq_ack_i = 1'b0;
		repeat (2) @(negedge ref_clk_i);
		chk({7'h00, irq_o}, 8'h00);
		$display("test software guard finished");
	endtask : t_sw_guard

	// Unmasked with the port quiet, an interrupt shows in the next cycle and stays until acknowledged
	task automatic t_irq;
		irq_req_i = 1'b1;
		@(negedge ref_clk_i);
		irq_req_i = 1'b0;
		chk({7'h00, irq_o}, 8'h01);
		repeat (2) @(negedge ref_clk_i);
		chk({7'h00, irq_o}, 8'h01);
		irq_ack_i = 1'b1;
		@(negedge ref_clk_i);
		irq_ack_i = 1'b0;
		chk({7'h00, irq_o}, 8'h00);
		$display("test interrupt finished");
	endtask : t_irq

	// Update: unlock frame, restart in mid-run, then the relock frame comes before any fetch
	task automatic t_update;
		irq_mask_i = 1'b1;
		sw_frame(UNLOCK_CMD, PROT_NONE);
		irq_mask_i = 1'b0;
		sys_rst_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		chk({7'h00, flash_select_n_o}, 8'h01);
		chk({6'h00, fetch_done_o}, 8'h00);
		chk(fetch_data_o, 8'h00);
		chk({7'h00, sw_active_o}, 8'h00);
		@(negedge ref_clk_i);
		irq_mask_i = 1'b1;
		sw_frame(LOCK_CMD, PROT_ALL);
		irq_mask_i = 1'b0;
		$display("test update finished");
	endtask : t_update

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		@(negedge ref_clk_i);
		t_fetch();
		t_sw_guard();
		t_irq();
		t_update();
		t_fetch();
		wrap_up();
	end

	// Twelve frames of under 120 cycles each plus a restart; this limit is far above that
	initial begin
		#2000000;
		err_total++;
		wrap_up();
	end
endmodule : test_fpg_guard

bind fpg_guard fpg_guard_chk u_fpg_guard_chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
	.link_clk_i(link_clk_i), .fetch_done_o(fetch_done_o), .sw_own_i(sw_own_i), .sw_byte_valid_i(sw_byte_valid_i),
	.sw_ready_o(sw_ready_o), .sw_done_o(sw_done_o), .sw_active_o(sw_active_o), .irq_req_i(irq_req_i),
	.irq_mask_i(irq_mask_i), .irq_ack_i(irq_ack_i), .irq_o(irq_o), .flash_select_n_o(flash_select_n_o),
	.flash_sclk_o(flash_sclk_o), .flash_serial_out_o(flash_serial_out_o));
